// ==== hdl/bridge_pwm_output_stage.sv ====
// Enhanced PWM output stage with Avalon-MM register access
`timescale 1ns/10ps
module bridge_pwm_output_stage (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rstn,
  input  wire logic                        i_ce,
  input  wire logic [pwm_pkg::ADDR_W-1:0]  i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [31:0]                 o_avs_readdata,
  output logic                             o_avs_waitrequest,
  output logic                             o_out_a,
  output logic                             o_out_b,
  output logic                             o_out_c,
  output logic                             o_out_d
);
  import pwm_pkg::*;

  // Registers; all but duty_latch are software-visible
  logic [7:0] pwm_control_reg;     // Config, duty LSbs, mode
  logic [7:0] duty_upper_reg;      // Duty MSbs
  logic [7:0] duty_shadow_reg;     // Active duty MSbs
  logic [1:0] duty_latch;          // Active duty LSbs
  logic [7:0] period_compare_reg;  // Period end count
  logic [2:0] timer_control_reg;   // Enable and prescale select
  logic [6:0] deadband_reg;        // Dead-band count
  logic [7:0] period_timer;        // Period count

  // Timebase
  logic [3:0] fine_cnt;            // Prescaler clocks
  logic [1:0] sub_cnt;             // Sub-cycle phase bits
  logic       timer_on;
  logic       step;                // Sub-cycle advance
  logic       last_count;          // Timer sits at the period value
  logic       period_start;        // Last clock of the period

  // Buffered settings for the running cycle
  out_cfg_t   cfg_act;
  logic [1:0] pol_act;
  logic       pwm_on;
  logic [6:0] db_act;

  // Waveform
  logic [9:0] duty_value;
  logic       duty_match;
  logic       raw;
  logic       wave;                // Waveform, already low in the matching count
  logic       pwm_mode_live;
  logic       dir_change;
  logic       dir_window;
  logic [3:0] act;                 // Active levels, pin D down to A

  // Bus handshake
  logic       req;
  logic       ack;
  logic       wr_en;
  logic [7:0] rd_mux;

  deadband_if db ();

  assign duty_value    = {duty_upper_reg, pwm_control_reg[DLSB_HI:DLSB_LO]};
  assign pwm_mode_live = (pwm_control_reg[MODE_HI:MODE_LO] == PWM_MODE);
  assign timer_on      = timer_control_reg[TON_BIT];
  assign step          = timer_on && (fine_cnt >= presc_max(timer_control_reg[PSC_HI:0]));
  assign last_count    = timer_on && (period_timer == period_compare_reg);
  assign period_start  = step && last_count && (sub_cnt == SUB_LAST);
  assign duty_match    = ({duty_shadow_reg, duty_latch} == {period_timer, sub_cnt});
  assign wave          = raw & ~duty_match;

  // One wait state, then the access completes
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack;
  assign wr_en             = i_ce & i_avs_write & ack & i_avs_byteenable[0];

  // Acknowledge pulse, frozen with the clock enable
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
    end else if (i_ce) begin
      ack <= req & ~ack;
    end
  end

  // Read data selection; unmapped offsets read zero
  always_comb begin
    case (i_avs_address)
      OFS_CTRL:     rd_mux = pwm_control_reg;
      OFS_DUTY:     rd_mux = duty_upper_reg;
      OFS_SHADOW:   rd_mux = duty_shadow_reg;
      OFS_PERIOD:   rd_mux = period_compare_reg;
      OFS_TCTRL:    rd_mux = {5'h00, timer_control_reg};
      OFS_DEADBAND: rd_mux = {1'b0, deadband_reg};
      OFS_TIMER:    rd_mux = period_timer;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle, stands while ack is high
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && !ack) begin
      o_avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // Writable control registers; direction bit accepted any time
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_control_reg    <= CTRL_RST;
      duty_upper_reg     <= DUTY_RST;
      period_compare_reg <= PERIOD_RST;
      timer_control_reg  <= TCTRL_RST;
      deadband_reg       <= DB_RST;
    end else if (wr_en) begin
      case (i_avs_address)
        OFS_CTRL:     pwm_control_reg    <= i_avs_writedata[7:0];
        OFS_DUTY:     duty_upper_reg     <= i_avs_writedata[7:0];
        OFS_PERIOD:   period_compare_reg <= i_avs_writedata[7:0];
        OFS_TCTRL:    timer_control_reg  <= i_avs_writedata[2:0];
        OFS_DEADBAND: deadband_reg       <= i_avs_writedata[6:0];
        default:      ;
      endcase
    end
  end

  // Duty shadow: period match load, software write only outside PWM mode
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      duty_shadow_reg <= DUTY_RST;
      duty_latch      <= 2'h0;
    end else if (i_ce) begin
      if (period_start) begin
        duty_shadow_reg <= duty_value[9:2];
        duty_latch      <= duty_value[1:0];
      end else if (wr_en && (i_avs_address == OFS_SHADOW) && !pwm_mode_live) begin
        duty_shadow_reg <= i_avs_writedata[7:0];
      end
    end
  end

  // Prescaler; a lowered select wraps at once instead of overrunning
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      fine_cnt <= 4'h0;
    end else if (i_ce && timer_on) begin
      if (step) begin
        fine_cnt <= 4'h0;
      end else begin
        fine_cnt <= fine_cnt + 4'h1;
      end
    end
  end

  // Period timer extended by two sub-cycle bits
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sub_cnt      <= 2'h0;
      period_timer <= 8'h00;
    end else if (i_ce && step) begin
      if (period_start) begin
        sub_cnt      <= 2'h0;
        period_timer <= 8'h00;
      end else begin
        sub_cnt <= sub_cnt + 2'h1;
        if (sub_cnt == SUB_LAST) begin
          period_timer <= period_timer + 8'h01;
        end
      end
    end
  end

  // Raw waveform: set at period start unless zero duty, clear on match
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      raw <= 1'b0;
    end else if (i_ce) begin
      if (period_start) begin
        raw <= (duty_value != 10'h000);
      end else if (duty_match) begin
        raw <= 1'b0;
      end
    end
  end

  // Control settings take effect only at the period boundary
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_act <= CFG_SINGLE;
      pol_act <= 2'h0;
      pwm_on  <= 1'b0;
    end else if (i_ce && period_start) begin
      cfg_act <= out_cfg_t'(pwm_control_reg[CFG_HI:CFG_LO]);
      pol_act <= pwm_control_reg[POL_AC:POL_BD];
      pwm_on  <= pwm_mode_live;
    end
  end

  // Dead-band count loads at the period boundary and again at the duty boundary
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      db_act <= DB_RST;
    end else if (i_ce && (period_start || (duty_match && raw))) begin
      db_act <= deadband_reg;
    end
  end

  assign db.raw   = wave;
  assign db.count = db_act;

  deadband_unit u_deadband (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .db        (db)
  );

  // Pending direction differs from the running full-bridge direction
  assign dir_change = pwm_on && cfg_act[0] && pwm_control_reg[CFG_LO]
                      && (pwm_control_reg[CFG_HI] != cfg_act[1]);
  // Last timer count lasts 4 clocks times the prescale value
  assign dir_window = dir_change && last_count;

  // Steering per configuration; window overrides before the boundary
  always_comb begin
    act = 4'h0;
    case (cfg_act)
      CFG_SINGLE: begin
        act[PIN_A] = wave;
      end
      CFG_HALF: begin
        act[PIN_A] = db.act_a;
        act[PIN_B] = db.act_b;
      end
      CFG_FULL_FWD: begin
        act[PIN_A] = 1'b1;
        act[PIN_D] = wave;
      end
      CFG_FULL_REV: begin
        act[PIN_C] = 1'b1;
        act[PIN_B] = wave;
      end
      default: begin
        act = 4'h0;
      end
    endcase
    if (dir_window) begin
      act[PIN_A] = ~pwm_control_reg[CFG_HI];
      act[PIN_C] = pwm_control_reg[CFG_HI];
      act[PIN_B] = 1'b0;
      act[PIN_D] = 1'b0;
    end
    if (!pwm_on) begin
      act = 4'h0;
    end
  end

  // Polarity last, then registered pins; the A/C and B/D pairs may each invert
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_out_a <= 1'b0;
      o_out_b <= 1'b0;
      o_out_c <= 1'b0;
      o_out_d <= 1'b0;
    end else if (i_ce) begin
      o_out_a <= act[PIN_A] ^ pol_act[POL_AC];
      o_out_b <= act[PIN_B] ^ pol_act[POL_BD];
      o_out_c <= act[PIN_C] ^ pol_act[POL_AC];
      o_out_d <= act[PIN_D] ^ pol_act[POL_BD];
    end
  end

  duty_form_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && period_start |=> {duty_shadow_reg, duty_latch} == $past(duty_value))
    else $error("Duty shadow not loaded from duty fields");

  shadow_hold_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    pwm_mode_live && !(i_ce && period_start) |=> $stable(duty_shadow_reg))
    else $error("Duty shadow changed in PWM mode");

  clear_match_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && !period_start && duty_match |=> !raw)
    else $error("Output not cleared on duty match");

  never_clear_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && raw && !period_start && (period_timer <= period_compare_reg)
    && ({duty_shadow_reg, duty_latch} > {period_compare_reg, SUB_LAST}) |=> raw)
    else $error("Output cleared although duty exceeds period");

  period_start_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && period_start |=> (raw == ($past(duty_value) != 10'h000))
    && (period_timer == 8'h00) && (sub_cnt == 2'h0))
    else $error("Period boundary did not restart the cycle");

  prescale_wrap_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && timer_on && (fine_cnt == presc_max(timer_control_reg[PSC_HI:0]))
    |=> fine_cnt == 4'h0)
    else $error("Prescaler did not wrap at its limit");

  half_pair_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    pwm_on && (cfg_act == CFG_HALF) |-> !(act[PIN_A] && act[PIN_B]))
    else $error("Half-bridge outputs active together");

  full_fwd_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    pwm_on && (cfg_act == CFG_FULL_FWD) && !dir_window
    |-> act[PIN_A] && !act[PIN_B] && !act[PIN_C] && (act[PIN_D] == wave))
    else $error("Forward full-bridge steering wrong");

  dir_window_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    dir_window |-> !act[PIN_B] && !act[PIN_D] && (act[PIN_A] != act[PIN_C]))
    else $error("Modulated outputs active during direction change");

  pin_polarity_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce |=> (o_out_b == $past(act[PIN_B] ^ pol_act[POL_BD]))
    && (o_out_c == $past(act[PIN_C] ^ pol_act[POL_AC])))
    else $error("Pin polarity not applied");
endmodule

// ==== hdl/deadband_unit.sv ====
// Dead-band generator for the complementary half-bridge pair
`timescale 1ns/10ps
module deadband_unit (
  input  wire logic  i_clk_sys,
  input  wire logic  i_rstn,
  input  wire logic  i_ce,
  deadband_if.unit   db
);
  import pwm_pkg::*;

  logic       raw_q;  // Waveform one clock ago
  logic [8:0] cnt;    // Remaining delay clocks
  logic [8:0] load;   // Delay minus the change cycle
  logic       edge_now;

  // Count in instruction cycles; change cycle itself counts as one
  assign load     = (db.count == 7'h00) ? 9'h000 : 9'(int'(db.count) * TCY_CLKS - 1);
  assign edge_now = (db.raw != raw_q);

  // Remember the previous waveform level
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      raw_q <= 1'b0;
    end else if (i_ce) begin
      raw_q <= db.raw;
    end
  end

  // Restart the delay on every edge; a long count never expires
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 9'h000;
    end else if (i_ce) begin
      if (edge_now) begin
        cnt <= load;
      end else if (cnt != 9'h000) begin
        cnt <= cnt - 9'h001;
      end
    end
  end

  // Active only once the delay has run out
  assign db.act_a = db.raw & (edge_now ? (db.count == 7'h00) : (cnt == 9'h000));
  assign db.act_b = ~db.raw & (edge_now ? (db.count == 7'h00) : (cnt == 9'h000));

  deadband_load_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_ce && edge_now && (db.count != 7'h00) |=> cnt == $past(load))
    else $error("Dead-band delay not loaded on edge");

  deadband_quiet_a : assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (cnt != 9'h000) && !edge_now |-> !db.act_a && !db.act_b)
    else $error("Output active inside dead-band");
endmodule

// ==== pkg/deadband_if.sv ====
// Signals between the output stage and its dead-band unit
`timescale 1ns/10ps
interface deadband_if;
  logic       raw;    // Undelayed PWM waveform
  logic [6:0] count;  // Buffered dead-band count
  logic       act_a;  // Delayed active level for A
  logic       act_b;  // Delayed active level for B
  modport ctrl (output raw, output count, input act_a, input act_b);
  modport unit (input raw, input count, output act_a, output act_b);
endinterface

// ==== pkg/pwm_pkg.sv ====
// Constants, field layout and helpers shared by the PWM output stage
// Summary of operation
// - Duty is upper byte above control bits 5:4
// - Duty copied to shadow only at period match
// - Shadow ignores writes while PWM mode selected
// - Output clears when shadow equals extended timer
// - Duty above period never clears the output
// - Four output configurations from two-bit field
// - Half-bridge: waveform on A, complement on B
// - Half-bridge delays active edges by dead-band count
// - Dead-band beyond active time keeps output inactive
// - Full-bridge: forward A on, D modulated; reverse C, B
// - New direction applies from next PWM cycle
// - Direction change switches unmodulated outputs one count early
// - Prescale 1, 4 or 16 from bits 1:0
// - Modulated outputs stay inactive until period begins
// - Full-bridge inserts no dead-band delay
// - Direction bit writable at any point in cycle
// - Field codes: single, forward, half, reverse
// - Mode codes 1100 to 1111 select pair polarity
// - Period match clears timer, sets output unless duty is zero, loads shadow
// - Controls load at period, dead-band at both period and duty boundary
package pwm_pkg;
  // Clock and instruction cycle timing
  localparam int CLK_NS   = 25;
  localparam int TCY_NS   = 100;
  localparam int TCY_CLKS = (TCY_NS + CLK_NS - 1) / CLK_NS;

  // Register bus byte offsets
  localparam int         ADDR_W       = 5;
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_DUTY     = 5'h04;
  localparam logic [4:0] OFS_SHADOW   = 5'h08;
  localparam logic [4:0] OFS_PERIOD   = 5'h0C;
  localparam logic [4:0] OFS_TCTRL    = 5'h10;
  localparam logic [4:0] OFS_DEADBAND = 5'h14;
  localparam logic [4:0] OFS_TIMER    = 5'h18;

  // Control register field positions
  localparam int CFG_HI  = 7;
  localparam int CFG_LO  = 6;
  localparam int DLSB_HI = 5;
  localparam int DLSB_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int POL_AC  = 1;
  localparam int POL_BD  = 0;
  localparam int TON_BIT = 2;
  localparam int PSC_HI  = 1;

  // Output pin indices
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  // Reset values, PWM mode code and last sub-cycle count
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] DUTY_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [2:0] TCTRL_RST  = 3'h0;
  localparam logic [6:0] DB_RST     = 7'h00;
  localparam logic [1:0] PWM_MODE   = 2'h3;
  localparam logic [1:0] SUB_LAST   = 2'h3;

  // Output configuration codes
  typedef enum logic [1:0] {
    CFG_SINGLE   = 2'b00,
    CFG_FULL_FWD = 2'b01,
    CFG_HALF     = 2'b10,
    CFG_FULL_REV = 2'b11
  } out_cfg_t;

  // Last prescaler count for a select code
  function automatic logic [3:0] presc_max(input logic [1:0] sel);
    case (sel)
      2'b00:   presc_max = 4'h0;
      2'b01:   presc_max = 4'h3;
      default: presc_max = 4'hF;
    endcase
  endfunction
endpackage

// ==== test/bridge_pwm_output_stage_tb.sv ====
// Self-checking bench for the bridge PWM output stage
`timescale 1ns/10ps
module bridge_pwm_output_stage_tb;
  import pwm_pkg::*;
  logic              i_clk_sys        = 1'b0; // 40 MHz clock
  logic              i_rstn           = 1'b0; // Reset, active low
  logic              i_ce             = 1'b1; // Clock enable
  logic [ADDR_W-1:0] i_avs_address    = '0;   // Bus request
  logic              i_avs_read       = 1'b0;
  logic              i_avs_write      = 1'b0;
  logic [31:0]       i_avs_writedata  = '0;
  logic [3:0]        i_avs_byteenable = 4'hF;
  logic [31:0]       o_avs_readdata;
  logic              o_avs_waitrequest;
  logic [3:0]        pins;                    // D C B A
  logic              arm              = 1'b0; // Partner watches legs
  logic [15:0]       shoot;                   // Shoot-through cycles
  logic [31:0]       rq[$];                   // Expected read data
  int                pq[$];                   // Expected high counts
  int                cnt[4];                  // High counts per pin
  int                left             = 0;    // Window cycles left
  int                failures         = 0;
  int                compares         = 0;
  int                cycles           = 0;
  int                seed;
  int                t;
  logic [9:0]        d10;
  logic [7:0]        r;
  logic              prev;

  bridge_pwm_output_stage i_bridge_pwm_output_stage (
    .i_clk_sys         (i_clk_sys),
    .i_rstn            (i_rstn),
    .i_ce              (i_ce),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_out_a           (pins[0]),
    .o_out_b           (pins[1]),
    .o_out_c           (pins[2]),
    .o_out_d           (pins[3])
  );

  switch_driver_model i_switch_driver_model (
    .i_clk_sys (i_clk_sys),
    .i_arm     (arm),
    .i_a       (pins[0]),
    .i_b       (pins[1]),
    .i_c       (pins[2]),
    .i_d       (pins[3]),
    .o_shoot   (shoot)
  );

  // Free running clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // Hang guard, the whole run needs well under this
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Read watcher: data taken at the edge that sees waitrequest low
  always @(posedge i_clk_sys) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && rq.size() > 0) begin
      check(o_avs_readdata, rq.pop_front());
    end
  end

  // Pin watcher: high counts against the oldest notes
  always @(negedge i_clk_sys) begin
    if (left > 0) begin
      for (int k = 0; k < 4; k++) begin
        cnt[k] += (pins[k] === 1'b1);
      end
      left--;
      if (left == 0) begin
        for (int k = 0; k < 4; k++) begin
          check(cnt[k], pq.pop_front());
          cnt[k] = 0;
        end
      end
    end
  end

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_read       <= rd;
    i_avs_write      <= ~rd;
    i_avs_address    <= a;
    i_avs_writedata  <= {24'h000000, d};
    i_avs_byteenable <= be;
    @(posedge i_clk_sys);
    while (o_avs_waitrequest !== 1'b0 && n < 64) begin
      n++;
      @(posedge i_clk_sys);
    end
    if (o_avs_waitrequest !== 1'b0) begin
      failures++;
      finish_test();
    end else begin
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 4'hF);
  endtask

  // Read with the expected byte noted first
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    bus(1'b1, a, 8'h00, 4'hF);
  endtask

  // Period in clocks for the fixed period value 3
  function automatic int per(input logic [1:0] psc);
    per = 16 * (psc == 2'b00 ? 1 : (psc == 2'b01 ? 4 : 16));
  endfunction

  // High-count window; a whole-period window makes the count phase free
  task automatic meas(input int w, input int ea, input int eb, input int ec,
                      input int ed);
    pq.push_back(ea);
    pq.push_back(eb);
    pq.push_back(ec);
    pq.push_back(ed);
    @(negedge i_clk_sys);
    left <= w;
    repeat (w) @(negedge i_clk_sys);
  endtask

  // Program a setting and let the period boundary buffer it
  task automatic setup(input logic [7:0] ctrl, input logic [7:0] duty,
                       input logic [1:0] psc, input logic [6:0] db);
    wr(OFS_CTRL, ctrl);
    wr(OFS_DUTY, duty);
    wr(OFS_DEADBAND, {1'b0, db});
    wr(OFS_TCTRL, {5'h00, 1'b1, psc});
    repeat (3 * per(psc)) @(negedge i_clk_sys);
  endtask

  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = $urandom(77412);
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    // Reset values, unmapped place, read-only timer, disabled byte lane
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_DUTY, DUTY_RST);
    rd(OFS_SHADOW, 8'h00);
    rd(OFS_PERIOD, PERIOD_RST);
    rd(OFS_TCTRL, {5'h00, TCTRL_RST});
    rd(OFS_DEADBAND, {1'b0, DB_RST});
    rd(OFS_TIMER, 8'h00);
    rd(5'h1C, 8'h00);
    bus(1'b0, OFS_PERIOD, 8'h55, 4'hE);
    rd(OFS_PERIOD, PERIOD_RST);
    wr(OFS_TIMER, 8'h33);
    rd(OFS_TIMER, 8'h00);
    wr(OFS_PERIOD, 8'h03);
    rd(OFS_PERIOD, 8'h03);
    // Duty buffering while the timer is stopped, then after a match
    r = 8'($urandom);
    wr(OFS_CTRL, 8'h3C);
    wr(OFS_DUTY, r);
    rd(OFS_SHADOW, 8'h00);
    rd(OFS_CTRL, 8'h3C);
    wr(OFS_SHADOW, 8'h5A);
    rd(OFS_SHADOW, 8'h00);
    wr(OFS_TCTRL, 8'h04);
    repeat (48) @(negedge i_clk_sys);
    rd(OFS_SHADOW, r);
    $display("test registers done");
    // Every prescale code with a random duty from 1 to 15, single output
    for (int c = 0; c < 4; c++) begin
      d10 = 10'(1 + $urandom % 15);
      setup({2'b00, d10[1:0], 4'hC}, {6'h00, d10[3:2]}, 2'(c), 7'h00);
      t = per(2'(c));
      meas(t, int'(d10) * t / 16, 0, 0, 0);
    end
    // Zero duty and duty above the period
    setup(8'h0C, 8'h00, 2'b00, 7'h00);
    meas(16, 0, 0, 0, 0);
    setup(8'h0C, 8'h05, 2'b00, 7'h00);
    meas(16, 16, 0, 0, 0);
    $display("test single done");
    // Full-bridge forward under every polarity code; pins A to D enabled
    for (int m = 0; m < 4; m++) begin
      setup(8'h4C + 8'(m), 8'h01, 2'b00, 7'h05);
      meas(16, m[1] ? 0 : 16, m[0] ? 16 : 0, m[1] ? 16 : 0,
           m[0] ? 12 : 4);
    end
    $display("test full done");
    // Half-bridge with dead-band, inverted pair levels, oversized band
    setup(8'h8C, 8'h02, 2'b00, 7'h01);
    arm <= 1'b1;
    meas(16, 4, 4, 0, 0);
    arm <= 1'b0;
    setup(8'h8F, 8'h02, 2'b00, 7'h01);
    meas(16, 12, 12, 16, 16);
    setup(8'h8C, 8'h02, 2'b00, 7'h03);
    meas(16, 0, 0, 0, 0);
    $display("test half done");
    // Direction change at low duty, written just after a period start
    setup(8'h4C, 8'h01, 2'b00, 7'h00);
    arm <= 1'b1;
    @(negedge i_clk_sys);
    prev = pins[3];
    @(negedge i_clk_sys);
    while (!(pins[3] === 1'b1 && prev === 1'b0)) begin
      prev = pins[3];
      @(negedge i_clk_sys);
    end
    fork
      wr(OFS_CTRL, 8'hCC);
    join_none
    repeat (10) @(negedge i_clk_sys);
    meas(4, 0, 0, 4, 0);
    meas(16, 0, 4, 16, 0);
    arm <= 1'b0;
    check(32'(shoot), 32'h0);
    $display("test direction done");
    finish_test();
  end
endmodule

// ==== test/switch_driver_model.sv ====
// Power switch driver model that counts shoot-through cycles on both legs
`timescale 1ns/10ps
module switch_driver_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arm,
  input  wire logic        i_a,
  input  wire logic        i_b,
  input  wire logic        i_c,
  input  wire logic        i_d,
  output logic      [15:0] o_shoot
);
  // Counter starts clean, the bench arms it only for active-high setups
  initial o_shoot = 16'h0000;

  // Upper and lower switch of one leg on together shorts the supply
  always @(negedge i_clk_sys) begin
    if (i_arm && ((i_a && i_b) || (i_c && i_d))) begin
      o_shoot <= o_shoot + 16'h0001;
    end
  end
endmodule
